//--- design/tcc_pkg.sv
// constants, field layout and state type of the timer/counter control block
// assumes a byte-wide register port and one 20 MHz clock taken as fc
// Functional notes
// - timer register loads on next source tick
// - low byte alone never changes register
// - second register writable only in pulse mode
// - control register resets to all zeros
// - bit 6 meaning depends on mode
// - bit 7 sets or clears output flip-flop while stopped
// - start field decodes stop, command, edges
// - source field selects divider tap or pin
// - mode field decodes three operating modes; MODE_PULSE only waits
// - stop power entry clears start field
// - capture copies counter every source tick
// - timer match raises interrupt, clears counter
package tcc_pkg;

	// register byte addresses
	localparam logic [15:0] OFS_A_LO = 16'h0010;
	localparam logic [15:0] OFS_A_HI = 16'h0011;
	localparam logic [15:0] OFS_B_LO = 16'h0012;
	localparam logic [15:0] OFS_B_HI = 16'h0013;
	localparam logic [15:0] OFS_CTRL = 16'h0014;

	// reset values
	localparam logic [15:0] TIMER_REG_RESET = 16'h0fff;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;

	// control field positions
	localparam int MODE_LSB  = 0;
	localparam int CLK_LSB   = 2;
	localparam int START_LSB = 4;
	localparam int OPT_BIT   = 6;
	localparam int TFF_BIT   = 7;

	// field codes
	localparam logic [1:0] MODE_TIMER  = 2'h0;
	localparam logic [1:0] MODE_WINDOW = 2'h1;
	localparam logic [1:0] MODE_PULSE  = 2'h2;
	localparam logic [1:0] MODE_PPG    = 2'h3;
	localparam logic [1:0] START_STOP  = 2'h0;
	localparam logic [1:0] START_CMD   = 2'h1;
	localparam logic [1:0] CLK_SLOWEST = 2'h0;
	localparam logic [1:0] CLK_MID     = 2'h1;
	localparam logic [1:0] CLK_FAST    = 2'h2;
	localparam logic [1:0] CLK_EXT     = 2'h3;

	// divider taps: fc/2^11, fc/2^7, fc/2^3, fs/2^3
	localparam int FC_DIV_BITS = 11;
	localparam int FC_MID_BITS = 7;
	localparam int FC_FAST_BITS = 3;
	localparam int FS_DIV_BITS = 3;

	typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN, ST_DONE} tcc_state_e;

	// field extraction used by several decoders
	function automatic logic [1:0] tcc_field(input logic [7:0] ctrl, input int lsb);
		tcc_field = ctrl[lsb +: 2];
	endfunction : tcc_field

endpackage : tcc_pkg

//--- design/tcc_tick_if.sv
// source tick and timer pin edges passed from the divider to the control logic
// assumes one clock; all members are one-cycle enables
`timescale 1ns/1ns
interface tcc_tick_if;
	logic tick;
	logic pin_rise;
	logic pin_fall;

	modport src  (output tick, output pin_rise, output pin_fall);
	modport sink (input tick, input pin_rise, input pin_fall);
endinterface : tcc_tick_if

//--- design/tcc_divider.sv
// prescaler and source select: makes the counting tick as a one-cycle enable
// assumes fs_tick is a one-cycle pulse at the low-frequency rate, pin synchronous
`timescale 1ns/1ns
module tcc_divider
	import tcc_pkg::*;
(
	// clock and reset
	input  wire logic   ref_clk,
	input  wire logic   rst_n,
	// selection
	input  wire logic [1:0] clk_sel,
	input  wire logic   edge_fall,
	input  wire logic   divider_input_select,
	input  wire logic   slow_mode,
	input  wire logic   fs_tick,
	input  wire logic   timer_input_pin,
	// ticks out
	tcc_tick_if.src     ticks
);

	logic [FC_DIV_BITS-1:0] fc_cnt;
	logic [FS_DIV_BITS-1:0] fs_cnt;
	logic                   pin_q;

	// free-running prescalers and pin history
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fc_cnt <= '0;
			fs_cnt <= '0;
			pin_q  <= 1'b0;
		end else begin
			fc_cnt <= fc_cnt + 1'b1;
			if (fs_tick)
				fs_cnt <= fs_cnt + 1'b1;
			pin_q  <= timer_input_pin;
		end
	end

	wire fc_slow_tick = &fc_cnt;
	wire fc_mid_tick  = &fc_cnt[FC_MID_BITS-1:0];
	wire fc_fast_tick = &fc_cnt[FC_FAST_BITS-1:0];
	wire fs_div_tick  = fs_tick & (&fs_cnt);
	wire low_source   = divider_input_select | slow_mode;

	// tap selection; fast taps are dead in slow modes
	assign ticks.pin_rise = timer_input_pin & ~pin_q;
	assign ticks.pin_fall = ~timer_input_pin & pin_q;
	assign ticks.tick = (clk_sel == CLK_SLOWEST) ? (low_source ? fs_div_tick : fc_slow_tick) :
	                    (clk_sel == CLK_MID)     ? (~slow_mode & fc_mid_tick) :
	                    (clk_sel == CLK_FAST)    ? (~slow_mode & fc_fast_tick) :
	                    (edge_fall ? ticks.pin_fall : ticks.pin_rise);

	a_slow_no_fast: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(slow_mode && (clk_sel == CLK_MID || clk_sel == CLK_FAST)) |-> !ticks.tick)
		else $error("fast tap ticked in slow mode");

endmodule : tcc_divider

//--- design/tcc_stage.sv
// one 16-bit timer register with byte staging and a capture load path
// assumes the caller gates writes; tick is the counting source enable
`timescale 1ns/1ns
module tcc_stage
	import tcc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// byte writes
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [7:0]  wdata,
	// load timing and capture
	input  wire logic        tick,
	input  wire logic        cap_en,
	input  wire logic [15:0] cap_val,
	// effective value
	output logic      [15:0] value
);

	logic [7:0]  lo_shift;
	logic [15:0] pend_val;
	logic        pend;

	// write staging: high byte arms the pair, tick makes it effective
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_shift <= TIMER_REG_RESET[7:0];
			pend_val <= TIMER_REG_RESET;
			pend     <= 1'b0;
		end else begin
			if (wr_lo)
				lo_shift <= wdata;
			if (wr_hi) begin
				pend_val <= {wdata, lo_shift};
				pend     <= 1'b1;
			end else if (tick)
				pend     <= 1'b0;
		end
	end

	// effective register; a pending write beats a capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			value <= TIMER_REG_RESET;
		else if (tick && pend)
			value <= pend_val;
		else if (tick && cap_en)
			value <= cap_val;
	end

	a_stage_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pend && tick) |=> value == $past(pend_val))
		else $error("staged value not loaded on tick");

	a_lo_no_effect: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_lo && !pend && !cap_en) |=> $stable(value))
		else $error("low byte write changed register");

endmodule : tcc_stage

//--- design/tcc_top.sv
// timer/counter control: register port, control decode, counter and output
// assumes a one-cycle strobe master, synchronous pins, stop entry as a pulse
`timescale 1ns/1ns
module tcc_top
	import tcc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// chip state
	input  wire logic        divider_input_select,
	input  wire logic        slow_mode,
	input  wire logic        stop_mode_entry,
	input  wire logic        fs_tick,
	// pins and events
	input  wire logic        timer_input_pin,
	output logic             programmable_pulse_output,
	output logic             timer_match_interrupt
);

	tcc_tick_if ticks ();

	logic [7:0]  timer_control;
	logic [15:0] up_count;
	logic [15:0] compare_value;
	logic [15:0] capture_or_duty_value;
	tcc_state_e  state;
	tcc_state_e  next_state;
	logic [15:0] next_count;
	logic        next_irq;
	logic        next_ff;

	// field decode
	wire [1:0] operating_mode_select = tcc_field(timer_control, MODE_LSB);
	wire [1:0] source_clock_select   = tcc_field(timer_control, CLK_LSB);
	wire [1:0] start_control         = tcc_field(timer_control, START_LSB);
	wire       option_bit            = timer_control[OPT_BIT];
	wire       output_flipflop_control = timer_control[TFF_BIT];

	// mode decode
	wire mode_base  = (operating_mode_select == MODE_TIMER);
	wire mode_win   = (operating_mode_select == MODE_WINDOW);
	wire mode_ppg   = (operating_mode_select == MODE_PPG);
	wire stopped    = (start_control == START_STOP);
	wire cmd_start  = (start_control == START_CMD);
	wire edge_start = start_control[1];
	wire is_timer   = mode_base & cmd_start;
	wire is_event   = mode_base & edge_start & (source_clock_select == CLK_EXT);
	wire is_trigger = mode_base & edge_start & (source_clock_select != CLK_EXT);

	// bit 6 readings by mode
	wire auto_capture_enable  = option_bit & (mode_base | mode_win) & ~is_trigger;
	wire trigger_stop_select  = option_bit & is_trigger;
	wire one_shot_select      = option_bit & mode_ppg;

	// trigger edge follows start field bit 0: 0 rising, 1 falling
	wire sel_edge = start_control[0] ? ticks.pin_fall : ticks.pin_rise;
	wire opp_edge = start_control[0] ? ticks.pin_rise : ticks.pin_fall;
	wire match_a  = (up_count == compare_value);
	wire match_b  = (up_count == capture_or_duty_value);
	wire running  = (state == ST_RUN);
	wire cap_on   = auto_capture_enable & running;

	// register write decode; duty register writes dropped outside pulse mode
	wire a_wr_lo = wr & (addr == OFS_A_LO);
	wire a_wr_hi = wr & (addr == OFS_A_HI);
	wire b_wr_lo = wr & (addr == OFS_B_LO) & mode_ppg;
	wire b_wr_hi = wr & (addr == OFS_B_HI) & mode_ppg;
	wire c_wr    = wr & (addr == OFS_CTRL);

	// read selection; unmapped addresses read zero
	wire [7:0] rd_mux = (addr == OFS_A_LO) ? compare_value[7:0] :
	                    (addr == OFS_A_HI) ? compare_value[15:8] :
	                    (addr == OFS_B_LO) ? capture_or_duty_value[7:0] :
	                    (addr == OFS_B_HI) ? capture_or_duty_value[15:8] :
	                    (addr == OFS_CTRL) ? timer_control : 8'h00;

	tcc_divider u_div (
		.ref_clk              (ref_clk),
		.rst_n                (rst_n),
		.clk_sel              (source_clock_select),
		.edge_fall            (start_control[0]),
		.divider_input_select (divider_input_select),
		.slow_mode            (slow_mode),
		.fs_tick              (fs_tick),
		.timer_input_pin      (timer_input_pin),
		.ticks                (ticks)
	);

	tcc_stage u_reg_a (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wr_lo   (a_wr_lo),
		.wr_hi   (a_wr_hi),
		.wdata   (wdata),
		.tick    (ticks.tick),
		.cap_en  (1'b0),
		.cap_val (16'h0000),
		.value   (compare_value)
	);

	tcc_stage u_reg_b (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wr_lo   (b_wr_lo),
		.wr_hi   (b_wr_hi),
		.wdata   (wdata),
		.tick    (ticks.tick),
		.cap_en  (cap_on),
		.cap_val (up_count),
		.value   (capture_or_duty_value)
	);

	// control register; stop power entry overrides a same-cycle write of the start field
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			timer_control <= CTRL_RESET;
		else if (stop_mode_entry)
			timer_control <= {(c_wr ? wdata[7:6] : timer_control[7:6]), START_STOP,
			                  (c_wr ? wdata[3:0] : timer_control[3:0])};
		else if (c_wr)
			timer_control <= wdata;
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rdata <= 8'h00;
		else
			rdata <= rd ? rd_mux : 8'h00;
	end

	// counter sequencing; windows and pulse width wait without counting
	always_comb begin
		next_state = state;
		next_count = up_count;
		next_irq   = 1'b0;
		next_ff    = programmable_pulse_output;
		unique case (state)
			ST_STOP: begin
				if (is_timer || is_event || (mode_ppg && cmd_start))
					next_state = ST_RUN;
				else if (!stopped)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if ((is_trigger || (mode_ppg && edge_start)) && sel_edge)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (trigger_stop_select && opp_edge) begin
					next_count = 16'h0000;
					next_state = ST_WAIT;
				end else if (ticks.tick) begin
					if (mode_ppg && (match_a || match_b))
						next_ff = ~programmable_pulse_output;
					if (match_a) begin
						next_irq   = 1'b1;
						next_count = 16'h0000;
						if (is_trigger)
							next_state = ST_WAIT;
						else if (one_shot_select)
							next_state = ST_DONE;
					end else
						next_count = up_count + 16'h0001;
				end
			end
			ST_DONE: begin
				next_state = ST_DONE;
			end
		endcase
		if (stopped) begin
			next_state = ST_STOP;
			next_count = 16'h0000;
			next_ff    = output_flipflop_control;
		end
	end

	// sequencer registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state                     <= ST_STOP;
			up_count                  <= 16'h0000;
			timer_match_interrupt     <= 1'b0;
			programmable_pulse_output <= 1'b0;
		end else begin
			state                     <= next_state;
			up_count                  <= next_count;
			timer_match_interrupt     <= next_irq;
			programmable_pulse_output <= next_ff;
		end
	end

	a_reset_ctrl_zero: assert property (@(posedge ref_clk)
		$rose(rst_n) |-> (timer_control == CTRL_RESET && state == ST_STOP))
		else $error("control not zero after reset");

	a_stop_entry_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		stop_mode_entry |=> (start_control == START_STOP) ##1 (state == ST_STOP && up_count == 16'h0000))
		else $error("stop entry did not halt counter");

	a_duty_write_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr && addr == OFS_B_HI && !mode_ppg && !cap_on) ##1 ticks.tick [*1] |=> $stable(capture_or_duty_value))
		else $error("duty register written outside pulse mode");

	a_match_irq_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(running && ticks.tick && match_a && !stopped && !(trigger_stop_select && opp_edge))
		|=> (timer_match_interrupt && up_count == 16'h0000))
		else $error("match did not raise interrupt and clear");

	a_stop_clears_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		stopped [*2] |-> (up_count == 16'h0000 && state == ST_STOP))
		else $error("stopped counter not clear");

	a_capture_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cap_on && ticks.tick) |=> capture_or_duty_value == $past(up_count))
		else $error("capture missed counter value");

	a_ff_follows_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		stopped |=> programmable_pulse_output == $past(output_flipflop_control))
		else $error("output flip-flop ignores control bit");

	a_one_shot_halt: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(running && ticks.tick && match_a && one_shot_select && !stopped) |=> state == ST_DONE [*1] ##1 !running)
		else $error("one-shot kept running");

	a_ctrl_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd && addr == OFS_CTRL && !stop_mode_entry) |=> rdata == $past(timer_control))
		else $error("control readback wrong");

	a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!rd |=> rdata == 8'h00)
		else $error("read data outside answer cycle");

endmodule : tcc_top

//--- tb/tcc_top_tb.sv
// self-checking bench for the timer/counter control block: register port, staging, modes
// assumes the block's own assertions are elaborated with it; bench drives every port itself
`timescale 1ns/1ns
module tcc_top_tb;
	import tcc_pkg::*;

	// clock, reset and register port
	logic        ref_clk              = 1'b0;
	logic        rst_n                = 1'b0;
	logic [15:0] addr                 = 16'h0000;
	logic [7:0]  wdata                = 8'h00;
	logic        wr                   = 1'b0;
	logic        rd                   = 1'b0;
	logic [7:0]  rdata;
	// chip state and pins, low-frequency path left idle
	logic        divider_input_select = 1'b0;
	logic        slow_mode            = 1'b0;
	logic        stop_mode_entry      = 1'b0;
	logic        fs_tick              = 1'b0;
	logic        timer_input_pin      = 1'b0;
	logic        programmable_pulse_output;
	logic        timer_match_interrupt;
	// bookkeeping
	int          bad_count   = 0;
	int          comparisons = 0;
	int          cyc         = 0;
	int          irq_count   = 0;
	int          last_irq    = 0;
	int          irq_gap     = 0;
	int          base;
	logic [7:0]  got;
	logic [7:0]  first_cap;

	tcc_top dut (
		.ref_clk                   (ref_clk),
		.rst_n                     (rst_n),
		.addr                      (addr),
		.wdata                     (wdata),
		.wr                        (wr),
		.rd                        (rd),
		.rdata                     (rdata),
		.divider_input_select      (divider_input_select),
		.slow_mode                 (slow_mode),
		.stop_mode_entry           (stop_mode_entry),
		.fs_tick                   (fs_tick),
		.timer_input_pin           (timer_input_pin),
		.programmable_pulse_output (programmable_pulse_output),
		.timer_match_interrupt     (timer_match_interrupt)
	);

	// 50 ns period
	always #25 ref_clk = ~ref_clk;

	// counts match pulses and the cycle gap between the last two
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (timer_match_interrupt === 1'b1) begin
			irq_count <= irq_count + 1;
			irq_gap   <= cyc - last_irq;
			last_irq  <= cyc;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		comparisons++;
		if (seen !== expected) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	// one-cycle write strobe
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr    <= 1'b0;
	endtask : wr_reg

	// one-cycle read strobe, data taken in the following cycle only
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic rd_check(input logic [15:0] a, input logic [7:0] expected);
		logic [7:0] d;
		rd_reg(a, d);
		check(16'(d), 16'(expected));
	endtask : rd_check

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	// watchdog: the sequence needs roughly 3500 cycles
	initial begin
		idle(20000);
		bad_count++;
		give_verdict();
	end

	initial begin
		idle(6);
		rst_n <= 1'b1;
		// reset values and an unmapped read
		rd_check(OFS_CTRL, CTRL_RESET);
		rd_check(OFS_A_LO, 8'hff);
		rd_check(OFS_A_HI, 8'h0f);
		rd_check(OFS_B_LO, 8'hff);
		rd_check(OFS_B_HI, 8'h0f);
		rd_check(16'h0020, 8'h00);
		rd_check(OFS_A_LO, 8'hff);
		idle(1);
		#1;
		check(16'(rdata), 16'h0000);
		// low byte alone, then high byte waits for a slow source tick
		wr_reg(OFS_A_LO, 8'h34);
		idle(30);
		rd_check(OFS_A_LO, 8'hff);
		wr_reg(OFS_A_HI, 8'h12);
		rd_check(OFS_A_LO, 8'hff);
		idle(2100);
		rd_check(OFS_A_LO, 8'h34);
		rd_check(OFS_A_HI, 8'h12);
		// duty writes ignored outside pulse output mode, taken inside it
		wr_reg(OFS_CTRL, 8'h08);
		wr_reg(OFS_B_LO, 8'h05);
		wr_reg(OFS_B_HI, 8'h00);
		idle(30);
		rd_check(OFS_B_LO, 8'hff);
		wr_reg(OFS_CTRL, 8'h0b);
		wr_reg(OFS_B_LO, 8'h02);
		wr_reg(OFS_B_HI, 8'h00);
		wr_reg(OFS_A_LO, 8'h03);
		wr_reg(OFS_A_HI, 8'h00);
		idle(30);
		rd_check(OFS_B_LO, 8'h02);
		rd_check(OFS_B_HI, 8'h00);
		rd_check(OFS_CTRL, 8'h0b);
		// one-shot versus continuous pulse output
		base = irq_count;
		wr_reg(OFS_CTRL, 8'h5b);
		idle(200);
		check(16'(irq_count - base), 16'h0001);
		wr_reg(OFS_CTRL, 8'h0b);
		base = irq_count;
		wr_reg(OFS_CTRL, 8'h1b);
		idle(200);
		check(16'(irq_count - base >= 6), 16'h0001);
		// flip-flop follows bit 7 while stopped, preset before any start
		wr_reg(OFS_CTRL, 8'h0b);
		wr_reg(OFS_CTRL, 8'h8b);
		idle(3);
		check(16'(programmable_pulse_output), 16'h0001);
		wr_reg(OFS_CTRL, 8'h0b);
		idle(3);
		check(16'(programmable_pulse_output), 16'h0000);
		// timer mode, fc/2^3 source, compare 3: four ticks of eight cycles
		wr_reg(OFS_CTRL, 8'h08);
		base = irq_count;
		wr_reg(OFS_CTRL, 8'h18);
		idle(150);
		check(16'(irq_gap), 16'h0020);
		check(16'(irq_count - base >= 4), 16'h0001);
		// auto-capture: five ticks apart in forty cycles
		wr_reg(OFS_CTRL, 8'h08);
		wr_reg(OFS_A_LO, 8'hff);
		wr_reg(OFS_A_HI, 8'h00);
		idle(30);
		wr_reg(OFS_CTRL, 8'h58);
		idle(100);
		rd_reg(OFS_B_LO, first_cap);
		idle(38);
		rd_reg(OFS_B_LO, got);
		check(16'(got - first_cap), 16'h0005);
		// window mode waits and never matches here
		wr_reg(OFS_CTRL, 8'h08);
		wr_reg(OFS_A_LO, 8'h03);
		wr_reg(OFS_A_HI, 8'h00);
		idle(30);
		base = irq_count;
		wr_reg(OFS_CTRL, 8'h29);
		idle(100);
		check(16'(irq_count - base), 16'h0000);
		// event counting on rising pin edges, compare still 3: two matches in eight edges
		wr_reg(OFS_CTRL, 8'h0c);
		base = irq_count;
		wr_reg(OFS_CTRL, 8'h2c);
		repeat (8) begin
			@(posedge ref_clk);
			timer_input_pin <= 1'b1;
			idle(3);
			timer_input_pin <= 1'b0;
			idle(3);
		end
		check(16'(irq_count - base), 16'h0002);
		// slow mode silences the fast tap, so no match can come
		wr_reg(OFS_CTRL, 8'h08);
		slow_mode <= 1'b1;
		base = irq_count;
		wr_reg(OFS_CTRL, 8'h18);
		idle(100);
		check(16'(irq_count - base), 16'h0000);
		wr_reg(OFS_CTRL, 8'h08);
		slow_mode <= 1'b0;
		// stop power entry clears only the start field and halts counting
		wr_reg(OFS_CTRL, 8'h08);
		wr_reg(OFS_CTRL, 8'h18);
		idle(50);
		@(posedge ref_clk);
		stop_mode_entry <= 1'b1;
		@(posedge ref_clk);
		stop_mode_entry <= 1'b0;
		idle(3);
		rd_check(OFS_CTRL, 8'h08);
		base = irq_count;
		idle(100);
		check(16'(irq_count - base), 16'h0000);
		// unmapped write leaves control alone
		wr_reg(16'h0020, 8'hff);
		rd_check(OFS_CTRL, 8'h08);
		give_verdict();
	end
endmodule : tcc_top_tb
